// ==== hw/apg_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "apg_defs.svh"
module apg_top (
   input wire logic clk, // 25 MHz clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire apg_pkg::apg_addr_t address, // Word address.
   input wire logic read, // Avalon read.
   input wire logic write, // Avalon write.
   input wire apg_pkg::apg_word_t writedata, // Write data.
   input wire logic [3:0] byteenable, // Byte enables.
   output apg_pkg::apg_word_t readdata, // Registered read data.
   output logic waitrequest, // Avalon waitrequest.
   input wire apg_pkg::apg_word_t pin_in, // Pin levels seen at the pads.
   output apg_pkg::apg_word_t pin_out, // Pin drive values.
   output apg_pkg::apg_word_t pin_oe // Pin output enables, high drives.
);
   import apg_pkg::*;
   apg_word_t pin_function_select;
   apg_word_t pin_direction;
   apg_word_t output_value;
   apg_word_t pin_sampled;
   apg_word_t be_mask;
   apg_state_e state;
   logic [7:0] byte_addr;
   logic hit;
   logic wr_ok;
   logic wr_func;
   logic wr_dir;
   logic wr_out;
   logic wr_set;
   logic wr_clr;
   logic rd_take;
   apg_word_t wr_bits;
   apg_word_t next_function;
   apg_word_t next_direction;
   apg_word_t next_output_value;
   apg_word_t next_readdata;
   apg_word_t drive_enable;
   apg_word_t drive_value;

   function automatic apg_word_t merge(input apg_word_t old,
                                       input apg_word_t val,
                                       input apg_word_t m);
      merge = ((old & ~m) | (val & m)) & `APG_IMPL_MASK;
   endfunction : merge

   // True when the decoded byte address names one register.
   function automatic logic addr_is(input logic [7:0] ba,
                                    input logic [7:0] ofs);
      addr_is = (ba == ofs);
   endfunction : addr_is

   function automatic apg_word_t set_bits(input apg_word_t old,
                                          input apg_word_t ones);
      set_bits = (old | ones) & `APG_IMPL_MASK;
   endfunction : set_bits

   function automatic apg_word_t clear_bits(input apg_word_t old,
                                            input apg_word_t ones);
      clear_bits = old & ~ones & `APG_IMPL_MASK;
   endfunction : clear_bits

   // A pin drives only in general-purpose mode and as an output.
   function automatic apg_word_t gate(input apg_word_t func,
                                      input apg_word_t dir);
      gate = func & dir & `APG_IMPL_MASK;
   endfunction : gate

   assign byte_addr = {address, 2'b00};
   assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
   // The access completes in the cycle after it is presented.
   assign hit = (state == apg_ack_e);
   assign waitrequest = (read | write) & ~hit;

   // A write takes effect only at the edge that ends its wait.
   assign wr_ok = write & ~waitrequest;
   assign wr_bits = writedata & be_mask;
   assign wr_func = wr_ok & addr_is(byte_addr, `APG_OFS_FUNC);
   assign wr_dir = wr_ok & addr_is(byte_addr, `APG_OFS_DIR);
   assign wr_out = wr_ok & addr_is(byte_addr, `APG_OFS_OUT);
   assign wr_set = wr_ok & addr_is(byte_addr, `APG_OFS_SET);
   assign wr_clr = wr_ok & addr_is(byte_addr, `APG_OFS_CLR);
   // Read data are captured on the first edge of the access.
   assign rd_take = read & (state == apg_idle_e);
   assign next_function = merge(pin_function_select, writedata, be_mask);
   assign next_direction = merge(pin_direction, writedata, be_mask);
   // One gate serves both the enable and the value of every pin.
   assign drive_enable = gate(pin_function_select,
                              pin_direction); // see RULE_06 RULE_14
   assign drive_value = output_value & drive_enable;

   apg_sync u_sync (
      .clk(clk),
      .rst(rst),
      .d(pin_in),
      .q(pin_sampled)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= apg_idle_e;
      end else begin
         unique case (state)
            apg_idle_e: begin
               if (read | write) begin
                  state <= apg_ack_e;
               end
            end
            apg_ack_e: begin
               state <= apg_idle_e;
            end
         endcase
      end
   end

   // The function select is kept per pin group; reserved bits hold no state.
   // Pins 31-25 take a select bit each.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_function_select[`APG_HI_MSB:`APG_HI_LSB] <= '0;
      end else if (wr_func) begin
         pin_function_select[`APG_HI_MSB:`APG_HI_LSB] <=
            next_function[`APG_HI_MSB:`APG_HI_LSB];
      end
   end

   // Reserved bits 24-16 stay zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_function_select[`APG_RSV_MSB:`APG_RSV_LSB] <= '0;
      end else begin
         pin_function_select[`APG_RSV_MSB:`APG_RSV_LSB] <= '0;
      end
   end

   // Serializer data pins 15-0 take a select bit each.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_function_select[`APG_LO_MSB:`APG_LO_LSB] <= '0;
      end else if (wr_func) begin
         pin_function_select[`APG_LO_MSB:`APG_LO_LSB] <=
            next_function[`APG_LO_MSB:`APG_LO_LSB];
      end
   end

   // Direction is kept per pin group, one process for each.
   // Receive frame sync, receive clocks and transmit frame sync, bits 31-28.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_direction[`APG_RX_MSB:`APG_RX_LSB] <= '0;
      end else if (wr_dir) begin
         pin_direction[`APG_RX_MSB:`APG_RX_LSB] <=
            next_direction[`APG_RX_MSB:`APG_RX_LSB]; // see RULE_13
      end
   end

   // Transmit high clock, transmit bit clock and mute, bits 27-25.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_direction[`APG_TX_MSB:`APG_TX_LSB] <= '0;
      end else if (wr_dir) begin
         pin_direction[`APG_TX_MSB:`APG_TX_LSB] <=
            next_direction[`APG_TX_MSB:`APG_TX_LSB]; // see RULE_01
      end
   end

   // Reserved bits 24-16 never take a write.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_direction[`APG_RSV_MSB:`APG_RSV_LSB] <= '0;
      end else begin
         pin_direction[`APG_RSV_MSB:`APG_RSV_LSB] <= '0; // see RULE_03
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_direction[`APG_DHI_MSB:`APG_DHI_LSB] <= '0;
      end else if (wr_dir) begin
         pin_direction[`APG_DHI_MSB:`APG_DHI_LSB] <=
            next_direction[`APG_DHI_MSB:`APG_DHI_LSB]; // see RULE_02
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_direction[`APG_DLO_MSB:`APG_DLO_LSB] <= '0;
      end else if (wr_dir) begin
         pin_direction[`APG_DLO_MSB:`APG_DLO_LSB] <=
            next_direction[`APG_DLO_MSB:`APG_DLO_LSB]; // see RULE_02
      end
   end

   // One store serves the plain address and both aliases.
   always_comb begin
      next_output_value = output_value; // see RULE_04 RULE_05
      if (wr_out) begin
         next_output_value = merge(output_value, writedata,
                                   be_mask); // see RULE_07 RULE_10
      end else if (wr_set) begin
         next_output_value = set_bits(output_value, wr_bits); // see RULE_08
      end else if (wr_clr) begin
         next_output_value = clear_bits(output_value, wr_bits); // see RULE_09
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         output_value <= `APG_RESET_VAL; // see RULE_11
      end else begin
         output_value <= next_output_value;
      end
   end

   // Set and clear addresses read back the shared store.
   always_comb begin
      next_readdata = readdata;
      if (rd_take) begin
         unique case (byte_addr)
            `APG_OFS_FUNC: begin
               next_readdata = pin_function_select;
            end
            `APG_OFS_DIR: begin
               next_readdata = pin_direction; // see RULE_03
            end
            `APG_OFS_OUT, `APG_OFS_SET, `APG_OFS_CLR: begin
               next_readdata = output_value; // see RULE_07
            end
            `APG_OFS_PIN: begin
               next_readdata = pin_sampled;
            end
            default: begin
               next_readdata = `APG_RESET_VAL;
            end
         endcase
      end
   end

   // Read data stand until the next read replaces them.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata <= `APG_RESET_VAL;
      end else begin
         readdata <= next_readdata;
      end
   end

   // Pin drive is registered, so pins move one edge after the write that
   // changes them, and each pin group has its own enable and value.
   // Receive frame sync, receive clocks and transmit frame sync.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_oe[`APG_RX_MSB:`APG_RX_LSB] <= '0;
      end else begin
         pin_oe[`APG_RX_MSB:`APG_RX_LSB] <=
            drive_enable[`APG_RX_MSB:`APG_RX_LSB]; // see RULE_13
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out[`APG_RX_MSB:`APG_RX_LSB] <= '0;
      end else begin
         pin_out[`APG_RX_MSB:`APG_RX_LSB] <=
            drive_value[`APG_RX_MSB:`APG_RX_LSB]; // see RULE_06
      end
   end

   // Transmit clocks and mute.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_oe[`APG_TX_MSB:`APG_TX_LSB] <= '0;
      end else begin
         pin_oe[`APG_TX_MSB:`APG_TX_LSB] <=
            drive_enable[`APG_TX_MSB:`APG_TX_LSB]; // see RULE_01
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out[`APG_TX_MSB:`APG_TX_LSB] <= '0;
      end else begin
         pin_out[`APG_TX_MSB:`APG_TX_LSB] <=
            drive_value[`APG_TX_MSB:`APG_TX_LSB]; // see RULE_06
      end
   end

   // Reserved positions never drive.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_oe[`APG_RSV_MSB:`APG_RSV_LSB] <= '0;
      end else begin
         pin_oe[`APG_RSV_MSB:`APG_RSV_LSB] <= '0; // see RULE_03
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out[`APG_RSV_MSB:`APG_RSV_LSB] <= '0;
      end else begin
         pin_out[`APG_RSV_MSB:`APG_RSV_LSB] <= '0; // see RULE_11
      end
   end

   // Upper serializer data pins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_oe[`APG_DHI_MSB:`APG_DHI_LSB] <= '0;
      end else begin
         pin_oe[`APG_DHI_MSB:`APG_DHI_LSB] <=
            drive_enable[`APG_DHI_MSB:`APG_DHI_LSB]; // see RULE_02
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out[`APG_DHI_MSB:`APG_DHI_LSB] <= '0;
      end else begin
         pin_out[`APG_DHI_MSB:`APG_DHI_LSB] <=
            drive_value[`APG_DHI_MSB:`APG_DHI_LSB]; // see RULE_06
      end
   end

   // Lower serializer data pins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_oe[`APG_DLO_MSB:`APG_DLO_LSB] <= '0;
      end else begin
         pin_oe[`APG_DLO_MSB:`APG_DLO_LSB] <=
            drive_enable[`APG_DLO_MSB:`APG_DLO_LSB]; // see RULE_02
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out[`APG_DLO_MSB:`APG_DLO_LSB] <= '0;
      end else begin
         pin_out[`APG_DLO_MSB:`APG_DLO_LSB] <=
            drive_value[`APG_DLO_MSB:`APG_DLO_LSB]; // see RULE_06
      end
   end
endmodule : apg_top
`default_nettype wire

// ==== hw/apg_defs.svh ====
// Operation
// (RULE_01) Direction bits 27, 26 and 25 make the transmit high clock, transmit bit clock and mute pins inputs at 0 and outputs at 1.
// (RULE_02) Direction bits 15-8 and 7-0 make the matching serializer data pins inputs at 0 and outputs at 1.
// (RULE_03) Direction bits 24-16 always read zero and ignore writes.
// (RULE_04) The output value is held at all times and can always be read back.
// (RULE_05) Writing the direction or function-select register leaves the output value alone.
// (RULE_06) A pin is driven from its output-value bit only when its function bit and direction bit are both 1.
// (RULE_07) Reading the output value returns the stored bits, not the pin levels, and a write stores the written value.
// (RULE_08) A write to the set alias sets every output-value bit written as 1 and leaves the others.
// (RULE_09) A write to the clear alias clears every output-value bit written as 1 and leaves the others.
// (RULE_10) The output value and both aliases act on one shared 32-bit store.
// (RULE_11) All implemented output-value bits reset to zero, bits 24-16 are reserved and read zero.
// (RULE_12) Software writes only zero to reserved or unimplemented output-value bits.
// (RULE_13) Direction bits 31-28 make the receive frame sync, receive high clock, receive bit clock and transmit frame sync pins inputs at 0 and outputs at 1.
// (RULE_14) A pin set as an input has its driver released.
`ifndef APG_DEFS_SVH
`define APG_DEFS_SVH
`define APG_OFS_FUNC 8'h10
`define APG_OFS_DIR 8'h14
`define APG_OFS_OUT 8'h18
`define APG_OFS_SET 8'h1c
`define APG_OFS_CLR 8'h20
`define APG_IMPL_MASK 32'hfe00ffff
`define APG_RESET_VAL 32'h00000000
`define APG_ADDR_LSB 2
`define APG_OFS_PIN 8'h24
`define APG_RX_MSB 31
`define APG_RX_LSB 28
`define APG_TX_MSB 27
`define APG_TX_LSB 25
`define APG_RSV_MSB 24
`define APG_RSV_LSB 16
`define APG_DHI_MSB 15
`define APG_DHI_LSB 8
`define APG_DLO_MSB 7
`define APG_DLO_LSB 0
`define APG_HI_MSB 31
`define APG_HI_LSB 25
`define APG_LO_MSB 15
`define APG_LO_LSB 0
`endif

// ==== hw/apg_pkg.sv ====
`include "apg_defs.svh"
package apg_pkg;
   typedef logic [31:0] apg_word_t;
   typedef logic [5:0] apg_addr_t;
   typedef enum logic [1:0] {
      apg_idle_e = 2'h0,
      apg_ack_e = 2'h1
   } apg_state_e;
endpackage : apg_pkg

// ==== hw/apg_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module apg_sync (
   input wire logic clk, // Clock.
   input wire logic rst, // Asynchronous reset.
   input wire logic [31:0] d, // Raw pin levels.
   output logic [31:0] q // Synchronised levels.
);
   logic [31:0] stage1;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= 32'h0;
         q <= 32'h0;
      end else begin
         stage1 <= d;
         q <= stage1;
      end
   end
endmodule : apg_sync
`default_nettype wire

// ==== sim/apg_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module apg_sva (
   input wire logic clk, // Clock.
   input wire logic rst, // Reset.
   input wire apg_pkg::apg_addr_t address, // Address.
   input wire logic read, // Read.
   input wire logic write, // Write.
   input wire apg_pkg::apg_word_t readdata, // Read data.
   input wire logic waitrequest, // Wait.
   input wire apg_pkg::apg_word_t pin_out, // Drive.
   input wire apg_pkg::apg_word_t pin_oe // Enable.
);
   import apg_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence w_s;
      waitrequest ##1 !waitrequest;
   endsequence
   wait_one_a: assert property ($rose(read || write) |-> w_s)
      else $error("wait state count wrong");
   drive_gate_a: assert property ((pin_out & ~pin_oe) == 32'h0)
      else $error("released pin driven");
   oe_resv_a: assert property (pin_oe[24:16] == 9'h0)
      else $error("reserved pin enabled");
   out_resv_a: assert property (pin_out[24:16] == 9'h0)
      else $error("reserved pin driven");
   rd_resv_a: assert property (read && !waitrequest &&
      address inside {[6'h5:6'h8]} |-> readdata[24:16] == 9'h0)
      else $error("reserved bits read nonzero");
   rd_hold_a: assert property ($changed(readdata) |-> $past(read))
      else $error("read data moved unasked");
   out_hold_a: assert property ($changed(pin_out) |->
      $past(write) || $past(write, 2))
      else $error("pin drive moved unasked");
   unmapped_a: assert property (read && !waitrequest &&
      address > 6'h9 |-> readdata == 32'h0)
      else $error("unmapped read nonzero");
endmodule : apg_sva
bind apg_top apg_sva i_sva (.clk(clk), .rst(rst), .address(address),
   .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ==== sim/apg_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module apg_board (
   input wire apg_pkg::apg_word_t pin_out, // Drive.
   input wire apg_pkg::apg_word_t pin_oe, // Enable.
   input wire apg_pkg::apg_word_t ext, // Board level.
   output apg_pkg::apg_word_t pad // Pad level.
);
   import apg_pkg::*;
   // The board wins on every pad that the block has released.
   assign pad = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : apg_board
`default_nettype wire

// ==== sim/test_audio_port_gpio_direction_output.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_audio_port_gpio_direction_output;
   import apg_pkg::*;
   logic clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, waitrequest;
   apg_addr_t address = 6'h0;
   apg_word_t writedata = 32'h0, q, readdata, pin_out, pin_oe, pad;
   int failures = 0, n_compared = 0;
   logic [3:0] byteenable = 4'hf, be_next = 4'hf;
   apg_top i_dut (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .pin_in(pad),
      .pin_out(pin_out), .pin_oe(pin_oe));
   apg_board i_brd (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext(32'ha5a5a5a5), .pad(pad));
   task automatic chk(input string s, input apg_word_t e, input apg_word_t g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input apg_addr_t a, input apg_word_t d);
      logic done;
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      byteenable <= be_next;
      done = 1'h0;
      while (!done) begin
         @(negedge clk);
         done = (waitrequest === 1'h0);
         @(posedge clk);
      end
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask : bus
   task automatic rd(input apg_addr_t a, input apg_word_t e);
      bus(1'h0, a, 32'h0);
      chk("readdata", e, q);
   endtask : rd
   task automatic t_reset;
      rd(6'h6, 32'h0);
      rd(6'h5, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_alias;
      bus(1'h1, 6'h6, 32'hfe00ffff);
      rd(6'h6, 32'hfe00ffff);
      bus(1'h1, 6'h8, 32'h0000ff00);
      rd(6'h6, 32'hfe0000ff);
      bus(1'h1, 6'h7, 32'h00000f00);
      rd(6'h7, 32'hfe000fff);
      be_next = 4'h2;
      bus(1'h1, 6'h7, 32'h0000f0f0);
      be_next = 4'hf;
      rd(6'h6, 32'hfe00ffff);
      $display("alias test done");
   endtask : t_alias
   task automatic t_pins;
      bus(1'h1, 6'h4, 32'hffffffff);
      bus(1'h1, 6'h5, 32'hffff0f0f);
      rd(6'h5, 32'hfe000f0f);
      rd(6'h6, 32'hfe00ffff);
      repeat (4) @(posedge clk);
      chk("pin_oe", 32'hfe000f0f, pin_oe);
      chk("pin_out", 32'hfe000f0f, pin_out);
      rd(6'h9, 32'hffa5afaf);
      bus(1'h1, 6'h5, 32'h0);
      repeat (4) @(posedge clk);
      chk("pin_oe", 32'h0, pin_oe);
      rd(6'h9, 32'ha5a5a5a5);
      rd(6'h6, 32'hfe00ffff);
      rd(6'h3f, 32'h0);
      $display("pin test done");
   endtask : t_pins
   task automatic complete_run;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      forever #20 clk = ~clk;
   end
   initial begin
      #20000;
      failures++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_alias();
      t_pins();
      complete_run();
   end
endmodule : test_audio_port_gpio_direction_output
`default_nettype wire
